// *** core/gmcs_pkg.sv ***
// gmcs_pkg: constants and types for the mac control and status block
package gmcs_pkg;
    localparam logic [9:0]  OFS_TXCS  = 10'h200;
    localparam logic [9:0]  OFS_ANEG  = 10'h204;
    localparam logic [9:0]  OFS_ADRH  = 10'h208;
    localparam logic [9:0]  OFS_ADRL  = 10'h20C;
    localparam logic [9:0]  OFS_SEED  = 10'h210;
    localparam logic [9:0]  OFS_LENS  = 10'h214;
    localparam logic [9:0]  OFS_THR   = 10'h21C;
    localparam logic [9:0]  OFS_RXCS  = 10'h220;
    localparam int          TX_XON    = 29;
    localparam int          TX_XOFF   = 28;
    localparam int          TX_XOFFD  = 20;
    localparam int          TX_LONG   = 13;
    localparam int          TX_CARR   = 12;
    localparam int          TX_NOCMP  = 11;
    localparam int          TX_BIGBO  = 10;
    localparam int          TX_FCATT  = 9;
    localparam int          TX_FCSND  = 8;
    localparam int          TX_CHKCAR = 3;
    localparam int          TX_STOP   = 2;
    localparam int          TX_EN     = 1;
    localparam int          TX_RST    = 0;
    localparam int          RX_LOWEN  = 22;
    localparam int          RX_FCATT  = 21;
    localparam int          RX_REMOFF = 20;
    localparam int          RX_FCRCV  = 16;
    localparam int          RX_PROMIS = 3;
    localparam logic [31:0] TX_WMASK  = 32'h0000_2FFE;
    localparam logic [31:0] RX_WMASK  = 32'h0061_FFFE;
    localparam logic [31:0] LEN_WMASK = 32'hFFFF_7FFF;
    localparam logic [7:0]  RX_W1C    = 8'hF7;
    localparam logic [31:0] CTRL_RST  = 32'h0000_0000;
    localparam logic [15:0] PAUSE_LNG = 16'hFFFF;
    localparam logic [15:0] PAUSE_SHT = 16'h01FF;
    localparam logic [15:0] PAUSE_ZRO = 16'h0000;
    localparam logic [9:0]  LFSR_TAP  = 10'h321;
    localparam logic [2:0]  THR_PAD   = 3'h7;
    localparam logic [4:0]  BO_MAXEXP = 5'h0A;
    localparam logic [4:0]  BO_BIGCOL = 5'h02;
    localparam logic [6:0]  IPG_EXTRA = 7'h02;
    typedef struct packed {
        logic enc8b10b;
        logic gbase;
        logic full_dpx;
        logic gmii;
    } gmcs_link_t;
    typedef struct packed {
        logic [15:0] quanta;
        logic [47:0] src;
    } gmcs_pause_t;
endpackage

// *** core/gmcs_top.sv ***
// gmcs_top: mac control and status registers with pause, backoff and gap logic
`timescale 1ns/1ps
module gmcs_top (
    input  wire logic                 clk,
    input  wire logic                 rst_n,
    input  wire logic                 tx_clk,
    input  wire logic                 reg_wr,
    input  wire logic                 reg_rd,
    input  wire logic [9:0]           reg_addr,
    input  wire logic [31:0]          reg_wdata,
    output logic      [31:0]          reg_rdata_q,
    input  wire logic                 carrier_pin,
    input  wire logic                 tx_busy,
    input  wire logic                 byte_tick,
    input  wire logic                 pkt_ready,
    input  wire logic                 pkt_partial,
    input  wire logic                 collision,
    input  wire logic [4:0]           coll_count,
    input  wire logic                 rx_resume,
    input  wire logic                 rx_stop,
    input  wire logic [3:0]           tx_fifo_err,
    input  wire logic                 rx_fifo_ovr,
    input  wire logic                 an_change,
    input  wire logic                 link_err,
    input  wire logic                 link_change,
    input  wire logic                 an_active,
    input  wire logic                 an_byte_tick,
    input  wire logic [7:0]           free_bufs,
    input  wire logic [7:0]           free_descs,
    input  wire logic [47:0]          rx_dest,
    input  wire logic                 rx_dest_vld,
    output logic                      mac_rst_q,
    output gmcs_pkg::gmcs_link_t      link_mode_q,
    output logic                      tx_go_q,
    output logic                      pause_req_q,
    output gmcs_pkg::gmcs_pause_t     pause_frm_q,
    output logic      [10:0]          backoff_q,
    output logic      [6:0]           ipg_len_q,
    output logic      [3:0]           crs_win_q,
    output logic      [9:0]           slot_len_q,
    output logic      [7:0]           an_byte_q,
    output logic                      addr_ok_q,
    output logic                      tx_attn_sys_q,
    output logic                      rx_attn_sys_q
);
    import gmcs_pkg::*;

    logic [31:0] tx_ctl_q;
    logic [1:0]  tx_flg_q;
    logic [3:0]  tx_ferr_q;
    logic        xoffd_q;
    logic [31:0] rx_ctl_q;
    logic [7:0]  rx_evt_q;
    logic        remote_q;
    logic [15:0] an_word_q;
    logic [15:0] adr_hi_q;
    logic [31:0] adr_lo_q;
    logic [9:0]  lfsr_q;
    logic [31:0] lens_q;
    logic [29:0] thr_q;
    logic [6:0]  ipg_cnt_q;
    logic        busy_q;
    logic        an_sel_q;
    logic        car_m_q;
    logic        carrier_s;
    logic        tx_attn_q;
    logic        rx_attn_q;
    logic [1:0]  att_m_q;
    logic [31:0] tx_rd;
    logic [31:0] rx_rd;
    logic        wr_tx;
    logic        wr_rx;
    logic        lfsr_ld;
    logic [9:0]  lfsr_d;
    logic [6:0]  ipg_len_d;
    logic        xoff_need;
    logic        xon_ok;
    logic        xoff_send;
    logic        xon_send;
    logic [7:0]  rx_set;
    logic [7:0]  rx_clr;
    logic [1:0]  tx_fl_set;
    logic        tx_go_d;

    function automatic logic thr_below(input logic [7:0] c, input logic [4:0] f);
        return (f != 5'h00) && (c < {f, THR_PAD});
    endfunction

    function automatic logic thr_atleast(input logic [7:0] c, input logic [4:0] f);
        return (f != 5'h00) && (c >= {f, THR_PAD});
    endfunction

    function automatic logic [10:0] bo_calc(input logic [9:0] r, input logic [4:0] n,
                                            input logic dbl);
        logic [4:0]  k;
        logic [10:0] m;
        k = (n > BO_MAXEXP) ? BO_MAXEXP : n;
        k = k + {4'h0, dbl};
        m = 11'((12'h001 << k) - 12'h001);
        return {r, r[9]} & m;
    endfunction

    assign wr_tx   = reg_wr && (reg_addr == OFS_TXCS);
    assign wr_rx   = reg_wr && (reg_addr == OFS_RXCS);
    assign lfsr_ld = reg_wr && (reg_addr == OFS_SEED);
    assign lfsr_d  = {lfsr_q[8:0], 1'b0} ^ (lfsr_q[9] ? LFSR_TAP : 10'h000);

    // read views assemble stored control with live status
    always_comb begin
        tx_rd            = tx_ctl_q;
        tx_rd[29:28]     = tx_flg_q;
        tx_rd[27:24]     = tx_ferr_q;
        tx_rd[TX_XOFFD]  = xoffd_q;
        tx_rd[TX_CARR]   = carrier_s;
        rx_rd            = rx_ctl_q;
        rx_rd[31:24]     = rx_evt_q;
        rx_rd[RX_REMOFF] = remote_q;
    end

    // register writes, all on the transmit clock
    always_ff @(posedge tx_clk or negedge rst_n) begin
        if (!rst_n) begin
            tx_ctl_q  <= CTRL_RST;
            rx_ctl_q  <= CTRL_RST;
            an_word_q <= 16'h0000;
            adr_hi_q  <= 16'h0000;
            adr_lo_q  <= CTRL_RST;
            lens_q    <= CTRL_RST;
            thr_q     <= 30'h0000_0000;
        end else begin
            if (wr_tx) begin
                tx_ctl_q <= reg_wdata & TX_WMASK;
            end else if (tx_ctl_q[TX_STOP] && !tx_busy) begin
                tx_ctl_q[TX_STOP] <= 1'b0;
                tx_ctl_q[TX_EN]   <= 1'b0;
            end
            if (wr_rx) begin
                rx_ctl_q <= reg_wdata & RX_WMASK;
            end
            if (reg_wr && reg_addr == OFS_ANEG) begin
                an_word_q <= reg_wdata[15:0];
            end
            if (reg_wr && reg_addr == OFS_ADRH) begin
                adr_hi_q <= reg_wdata[15:0];
            end
            if (reg_wr && reg_addr == OFS_ADRL) begin
                adr_lo_q <= reg_wdata;
            end
            if (reg_wr && reg_addr == OFS_LENS) begin
                lens_q <= reg_wdata & LEN_WMASK;
            end
            if (reg_wr && reg_addr == OFS_THR) begin
                thr_q <= reg_wdata[29:0];
            end
        end
    end

    // read port answers one edge after the strobe; holes read zero
    always_ff @(posedge tx_clk or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata_q <= 32'h0000_0000;
        end else if (reg_rd) begin
            case (reg_addr)
                OFS_TXCS: reg_rdata_q <= tx_rd;
                OFS_ANEG: reg_rdata_q <= {16'h0000, an_word_q};
                OFS_ADRH: reg_rdata_q <= {16'h0000, adr_hi_q};
                OFS_ADRL: reg_rdata_q <= adr_lo_q;
                OFS_SEED: reg_rdata_q <= {22'h00_0000, lfsr_q};
                OFS_LENS: reg_rdata_q <= lens_q;
                OFS_THR:  reg_rdata_q <= {2'h0, thr_q};
                OFS_RXCS: reg_rdata_q <= rx_rd;
                default:  reg_rdata_q <= 32'h0000_0000;
            endcase
        end
    end

    // self-clearing mac reset pulse
    always_ff @(posedge tx_clk or negedge rst_n) begin
        if (!rst_n) begin
            mac_rst_q <= 1'b0;
        end else begin
            mac_rst_q <= wr_tx && reg_wdata[TX_RST];
        end
    end

    // carrier pin synchroniser
    always_ff @(posedge tx_clk or negedge rst_n) begin
        if (!rst_n) begin
            car_m_q   <= 1'b0;
            carrier_s <= 1'b0;
        end else begin
            car_m_q   <= carrier_pin;
            carrier_s <= car_m_q;
        end
    end

    // transmit status flags, set wins over write-one clear
    assign tx_fl_set = {rx_resume, rx_stop} & {2{rx_ctl_q[RX_FCATT]}};
    always_ff @(posedge tx_clk or negedge rst_n) begin
        if (!rst_n) begin
            tx_flg_q  <= 2'h0;
            tx_ferr_q <= 4'h0;
            xoffd_q   <= 1'b0;
        end else if (mac_rst_q) begin
            tx_flg_q  <= 2'h0;
            tx_ferr_q <= 4'h0;
            xoffd_q   <= 1'b0;
        end else begin
            tx_flg_q  <= (tx_flg_q & ~(wr_tx ? reg_wdata[29:28] : 2'h0)) | tx_fl_set;
            tx_ferr_q <= tx_ferr_q | tx_fifo_err;
            if (rx_ctl_q[RX_FCRCV] && rx_stop) begin
                xoffd_q <= 1'b1;
            end else if (rx_resume) begin
                xoffd_q <= 1'b0;
            end
        end
    end

    // pause frame generation from receive resources
    always_comb begin
        xoff_need = tx_ctl_q[TX_FCSND]
                  && (thr_below(free_bufs, thr_q[19:15])
                  || thr_below(free_descs, thr_q[14:10]));
        xon_ok    = thr_atleast(free_bufs, thr_q[9:5])
                  || thr_atleast(free_descs, thr_q[4:0]);
        xoff_send = !remote_q && xoff_need;
        xon_send  = remote_q && !xoff_need && xon_ok;
    end

    always_ff @(posedge tx_clk or negedge rst_n) begin
        if (!rst_n) begin
            remote_q    <= 1'b0;
            pause_req_q <= 1'b0;
            pause_frm_q <= '0;
        end else if (mac_rst_q) begin
            remote_q    <= 1'b0;
            pause_req_q <= 1'b0;
        end else begin
            pause_req_q <= xoff_send || xon_send;
            if (xoff_send) begin
                remote_q           <= 1'b1;
                pause_frm_q.quanta <= tx_ctl_q[TX_LONG] ? PAUSE_LNG : PAUSE_SHT;
            end else if (xon_send) begin
                remote_q           <= 1'b0;
                pause_frm_q.quanta <= PAUSE_ZRO;
            end
            pause_frm_q.src <= {adr_hi_q, adr_lo_q};
        end
    end

    // receive status events, bit 27 only cleared by reset
    always_comb begin
        rx_set    = 8'h00;
        rx_set[7] = rx_ctl_q[RX_LOWEN] && thr_below(free_descs, thr_q[24:20]);
        rx_set[6] = rx_ctl_q[RX_LOWEN] && thr_below(free_bufs, thr_q[29:25]);
        rx_set[5] = xon_send && tx_ctl_q[TX_FCATT];
        rx_set[4] = xoff_send && tx_ctl_q[TX_FCATT];
        rx_set[3] = rx_fifo_ovr;
        rx_set[2] = an_change;
        rx_set[1] = link_err;
        rx_set[0] = link_change;
        rx_clr    = wr_rx ? (reg_wdata[31:24] & RX_W1C) : 8'h00;
    end

    always_ff @(posedge tx_clk or negedge rst_n) begin
        if (!rst_n) begin
            rx_evt_q <= 8'h00;
        end else if (mac_rst_q) begin
            rx_evt_q <= 8'h00;
        end else begin
            rx_evt_q <= (rx_evt_q & ~rx_clr) | rx_set;
        end
    end

    // attention summaries, crossed into the system clock as levels
    always_ff @(posedge tx_clk or negedge rst_n) begin
        if (!rst_n) begin
            tx_attn_q <= 1'b0;
            rx_attn_q <= 1'b0;
        end else begin
            tx_attn_q <= |tx_rd[31:24];
            rx_attn_q <= |rx_rd[31:24];
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            att_m_q       <= 2'h0;
            tx_attn_sys_q <= 1'b0;
            rx_attn_sys_q <= 1'b0;
        end else begin
            att_m_q       <= {tx_attn_q, rx_attn_q};
            tx_attn_sys_q <= att_m_q[1];
            rx_attn_sys_q <= att_m_q[0];
        end
    end

    // link mode, timing lengths and address filter
    always_ff @(posedge tx_clk or negedge rst_n) begin
        if (!rst_n) begin
            link_mode_q <= '0;
            ipg_len_q   <= 7'h00;
            crs_win_q   <= 4'h0;
            slot_len_q  <= 10'h000;
            addr_ok_q   <= 1'b0;
        end else begin
            link_mode_q <= tx_ctl_q[7:4];
            ipg_len_q   <= ipg_len_d;
            crs_win_q   <= {({1'b0, lens_q[14:13]} + 3'h1), 1'b0};
            slot_len_q  <= {({1'b0, lens_q[7:0]} + 9'h001), 1'b0};
            addr_ok_q   <= rx_dest_vld && (rx_ctl_q[RX_PROMIS]
                        || rx_dest == {adr_hi_q, adr_lo_q});
        end
    end

    assign ipg_len_d = {({1'b0, lens_q[12:8]} + 6'h01), 1'b0}
                     + ((!tx_ctl_q[5] || tx_ctl_q[6]) ? IPG_EXTRA : 7'h00);

    // gap counter in bytes; in half duplex, carrier before the ignore window restarts it
    always_ff @(posedge tx_clk or negedge rst_n) begin
        if (!rst_n) begin
            ipg_cnt_q <= 7'h00;
            busy_q    <= 1'b0;
        end else if (mac_rst_q) begin
            ipg_cnt_q <= 7'h00;
            busy_q    <= 1'b0;
        end else begin
            busy_q <= tx_busy;
            if (busy_q && !tx_busy) begin
                ipg_cnt_q <= ipg_len_d;
            end else if (carrier_s && !tx_ctl_q[5] && ipg_cnt_q > {3'h0, crs_win_q}) begin
                ipg_cnt_q <= ipg_len_d;
            end else if (byte_tick && ipg_cnt_q != 7'h00) begin
                ipg_cnt_q <= ipg_cnt_q - 7'h01;
            end
        end
    end

    // start decision for the next packet
    always_comb begin
        tx_go_d = tx_ctl_q[TX_EN] && !tx_ctl_q[TX_STOP] && !xoffd_q
               && !tx_busy && !busy_q && ipg_cnt_q == 7'h00
               && (pkt_ready || (tx_ctl_q[TX_NOCMP] && pkt_partial))
               && !(tx_ctl_q[TX_CHKCAR] && carrier_s);
    end

    always_ff @(posedge tx_clk or negedge rst_n) begin
        if (!rst_n) begin
            tx_go_q <= 1'b0;
        end else begin
            tx_go_q <= tx_go_d && !mac_rst_q;
        end
    end

    // backoff lfsr and range
    always_ff @(posedge tx_clk or negedge rst_n) begin
        if (!rst_n) begin
            lfsr_q    <= 10'h000;
            backoff_q <= 11'h000;
        end else begin
            if (lfsr_ld) begin
                lfsr_q <= reg_wdata[9:0];
            end else if (collision) begin
                lfsr_q <= lfsr_d;
            end
            if (collision) begin
                backoff_q <= bo_calc(lfsr_q, coll_count, tx_ctl_q[TX_BIGBO]
                          && !tx_ctl_q[5] && coll_count >= BO_BIGCOL);
            end
        end
    end

    // negotiation word, high byte first
    always_ff @(posedge tx_clk or negedge rst_n) begin
        if (!rst_n) begin
            an_sel_q  <= 1'b0;
            an_byte_q <= 8'h00;
        end else if (!an_active) begin
            an_sel_q  <= 1'b0;
            an_byte_q <= an_word_q[15:8];
        end else if (an_byte_tick) begin
            an_sel_q  <= !an_sel_q;
            an_byte_q <= an_sel_q ? an_word_q[7:0] : an_word_q[15:8];
        end
    end

    default clocking cb @(posedge tx_clk); endclocking
    default disable iff (!rst_n);

    sequence s_rst_wr;
        wr_tx && reg_wdata[TX_RST];
    endsequence

    sequence s_rst_pulse;
        mac_rst_q ##1 !mac_rst_q;
    endsequence

    AST_TX_ATTN: assert property (|tx_flg_q |=> tx_attn_q)
        else $error("tx attention not raised");
    AST_XON_SET: assert property (rx_resume && rx_ctl_q[RX_FCATT] && !mac_rst_q |=> tx_flg_q[1])
        else $error("resume flag not set");
    AST_XON_CLR: assert property (wr_tx && reg_wdata[TX_XON] && !rx_resume |=> !tx_flg_q[1])
        else $error("resume flag not cleared");
    AST_FIFO_ERR: assert property (tx_fifo_err[0] && !mac_rst_q |=> tx_ferr_q[0] && tx_rd[24])
        else $error("fifo error not flagged");
    AST_PAUSE_LEN: assert property ($rose(remote_q) |-> pause_req_q
        && pause_frm_q.quanta == ($past(tx_ctl_q[TX_LONG]) ? PAUSE_LNG : PAUSE_SHT))
        else $error("stop pause duration wrong");
    AST_XOFFD_HOLD: assert property (xoffd_q |=> !tx_go_q)
        else $error("transmit started while paused");
    AST_WHOLE_PKT: assert property (tx_go_q |-> $past(pkt_ready || tx_ctl_q[TX_NOCMP]))
        else $error("start without whole packet");
    AST_SELF_CLR: assert property (s_rst_wr ##1 !reg_wr |-> s_rst_pulse)
        else $error("mac reset not self clearing");
    AST_AN_MSB: assert property (an_active && an_byte_tick && !an_sel_q
        |=> an_byte_q == $past(an_word_q[15:8]))
        else $error("negotiation high byte not first");
    AST_LFSR_STEP: assert property (collision && !lfsr_ld |=> lfsr_q == $past(lfsr_d))
        else $error("backoff lfsr step wrong");
    AST_LFSR_ZERO: assert property (lfsr_q == 10'h000 && !lfsr_ld |=> lfsr_q == 10'h000)
        else $error("zero seed left zero");
    AST_THR_ZERO: assert property (thr_q[29:25] == 5'h00 && thr_q[24:20] == 5'h00
        && !rx_evt_q[7] && !rx_evt_q[6] |=> !rx_evt_q[7] && !rx_evt_q[6])
        else $error("zero threshold fired");

endmodule

// *** tb/gmcs_phy_model.sv ***
// gmcs_phy_model: far-side phy model giving carrier and received pause frames
`timescale 1ns/1ps
module gmcs_phy_model (
    input  wire logic       tx_clk,
    input  wire logic       rst_n,
    input  wire logic [1:0] pause_cmd,
    input  wire logic       carrier_cmd,
    output logic            carrier_pin,
    output logic            rx_stop,
    output logic            rx_resume
);
    logic [1:0] cmd_q;
    assign carrier_pin = carrier_cmd;
    // a newly raised command bit yields one decoded pause frame, one cycle long
    assign rx_stop     = pause_cmd[0] & ~cmd_q[0];
    assign rx_resume   = pause_cmd[1] & ~cmd_q[1];
    always_ff @(posedge tx_clk or negedge rst_n) begin
        if (!rst_n) cmd_q <= 2'h0;
        else cmd_q <= pause_cmd;
    end
endmodule

// *** tb/testbench.sv ***
// testbench: register-level tests of the mac control and status block
`timescale 1ns/1ps
module testbench;
    import gmcs_pkg::*;
    logic        clk = '0, tx_clk = '0, rst_n = '0, reg_wr = '0, reg_rd = '0, tx_busy = '0;
    logic        byte_tick = '0, pkt_ready = '0, pkt_partial = '0, collision = '0;
    logic        rx_fifo_ovr = '0, an_change = '0, link_err = '0, link_change = '0;
    logic        an_active = '0, an_byte_tick = '0, rx_dest_vld = '0, carrier_cmd = '0;
    logic [1:0]  pause_cmd = '0;
    logic [3:0]  tx_fifo_err = '0, crs_win_q;
    logic [4:0]  coll_count = '0;
    logic [7:0]  free_bufs = 8'hFF, free_descs = 8'hFF, an_byte_q;
    logic [9:0]  reg_addr = '0, slot_len_q;
    logic [31:0] reg_wdata = '0, reg_rdata_q;
    logic [47:0] rx_dest = '0;
    logic        carrier_pin, rx_stop, rx_resume, mac_rst_q, tx_go_q, pause_req_q;
    logic        addr_ok_q, tx_attn_sys_q, rx_attn_sys_q;
    logic [10:0] backoff_q;
    logic [6:0]  ipg_len_q;
    gmcs_link_t  link_mode_q;
    gmcs_pause_t pause_frm_q, frm;
    int          failures = 0, compares = 0, nrst = 0, npz = 0, cyc = 0;

    gmcs_top i_gmcs_top (.*);
    gmcs_phy_model i_gmcs_phy_model (.*);

    initial forever #25 clk = ~clk;
    initial #1.3 forever #3 tx_clk = ~tx_clk;
    always @(posedge tx_clk) byte_tick <= ~byte_tick;
    always @(posedge tx_clk) begin
        nrst += int'(mac_rst_q === 1'b1);
        npz += int'(pause_req_q === 1'b1);
        if (pause_req_q === 1'b1) frm = pause_frm_q;
    end
    always @(posedge clk) if (++cyc == 1500) begin
        failures++;
        results();
    end

    task automatic chk(input logic [63:0] s, input logic [63:0] e);
        compares++;
        if (s !== e) begin
            failures++;
            $display("Error at %0t: seen %0h expected %0h", $time, s, e);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge tx_clk);
        #1;
    endtask
    task automatic wr(input logic [9:0] a, input logic [31:0] d);
        @(posedge tx_clk);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge tx_clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [9:0] a, input logic [31:0] e);
        @(posedge tx_clk);
        reg_rd   <= 1'b1;
        reg_addr <= a;
        @(posedge tx_clk);
        reg_rd <= 1'b0;
        #1 chk(64'(reg_rdata_q), 64'(e));
    endtask
    task automatic bufs(input logic [7:0] v);
        @(posedge tx_clk);
        free_bufs <= v;
        tick(4);
    endtask
    task automatic results();
        $display("failures %0d compares %0d", failures, compares);
        if (failures == 0 && compares > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    initial begin
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        tick(3);
        rd(OFS_TXCS, 32'h0);
        rd(10'h218, 32'h0);
        wr(OFS_TXCS, 32'hFFFF_FFFF);
        rd(OFS_TXCS, 32'h0000_2FF8);
        chk(64'(nrst), 64'h1);
        wr(OFS_TXCS, 32'h0000_00A0);
        wr(OFS_ANEG, 32'hFFFF_A55A);
        rd(OFS_ANEG, 32'h0000_A55A);
        chk(64'(link_mode_q), 64'hA);
        for (int i = 0; i < 2; i++) begin
            @(posedge tx_clk);
            an_active    <= 1'b1;
            an_byte_tick <= 1'b1;
            @(posedge tx_clk);
            an_byte_tick <= 1'b0;
            #1 chk(64'(an_byte_q), (i == 0) ? 64'hA5 : 64'h5A);
        end
        wr(OFS_LENS, 32'hABCD_A5FF);
        rd(OFS_LENS, 32'hABCD_25FF);
        chk(64'(ipg_len_q), 64'hC);
        chk(64'(crs_win_q), 64'h4);
        chk(64'(slot_len_q), 64'h200);
        wr(OFS_SEED, 32'h0);
        wr(OFS_ADRH, 32'hFFFF_1234);
        rd(OFS_ADRH, 32'h0000_1234);
        wr(OFS_ADRL, 32'h5678_9ABC);
        wr(OFS_THR, 32'hC200_8040);
        rd(OFS_THR, 32'h0200_8040);
        wr(OFS_RXCS, 32'h0061_0000);
        wr(OFS_TXCS, 32'h0000_2300);
        bufs(8'hF);
        chk(64'(npz), 64'h0);
        chk(64'(ipg_len_q), 64'hE);
        bufs(8'hE);
        chk(64'(npz), 64'h1);
        chk(64'(frm), {16'hFFFF, 48'h1234_5678_9ABC});
        rd(OFS_RXCS, 32'h5071_0000);
        @(posedge tx_clk);
        pause_cmd <= 2'h1;
        tick(4);
        rd(OFS_TXCS, 32'h1010_2300);
        repeat (3) @(posedge clk);
        #1 chk(64'(tx_attn_sys_q), 64'h1);
        chk(64'(rx_attn_sys_q), 64'h1);
        wr(OFS_TXCS, 32'h1000_2300);
        rd(OFS_TXCS, 32'h0010_2300);
        @(posedge tx_clk);
        pause_cmd <= 2'h3;
        tick(4);
        rd(OFS_TXCS, 32'h2000_2300);
        bufs(8'h17);
        chk(64'(npz), 64'h2);
        chk(64'(frm.quanta), 64'h0);
        wr(OFS_TXCS, 32'h0000_0300);
        bufs(8'hE);
        chk(64'(frm.quanta), 64'h01FF);
        @(posedge tx_clk);
        {tx_fifo_err, rx_fifo_ovr, an_change, link_err, link_change} <= 8'hFF;
        {collision, rx_dest_vld, carrier_cmd} <= 3'h7;
        coll_count <= 5'h3;
        rx_dest    <= 48'h1234_5678_9ABC;
        @(posedge tx_clk);
        {tx_fifo_err, rx_fifo_ovr, an_change, link_err, link_change} <= 8'h00;
        {collision, rx_dest_vld} <= 2'h0;
        #1 chk(64'(addr_ok_q), 64'h1);
        chk(64'(backoff_q), 64'h0);
        tick(4);
        rd(OFS_TXCS, 32'h2F00_1300);
        rd(OFS_RXCS, 32'h7F71_0000);
        wr(OFS_SEED, 32'hFFFF_FFFF);
        rd(OFS_SEED, 32'h0000_03FF);
        wr(OFS_TXCS, 32'h0000_0001);
        tick(2);
        chk(64'(nrst), 64'h2);
        rd(OFS_TXCS, 32'h0000_1000);
        @(posedge tx_clk);
        {carrier_cmd, pkt_partial} <= 2'h1;
        wr(OFS_TXCS, 32'h0000_0022);
        tick(3);
        chk(64'(tx_go_q), 64'h0);
        @(posedge tx_clk);
        pkt_ready <= 1'b1;
        tick(3);
        chk(64'(tx_go_q), 64'h1);
        @(posedge tx_clk);
        tx_busy <= 1'b1;
        tick(3);
        chk(64'(tx_go_q), 64'h0);
        @(posedge tx_clk);
        tx_busy <= 1'b0;
        tick(6);
        chk(64'(tx_go_q), 64'h0);
        tick(30);
        chk(64'(tx_go_q), 64'h1);
        wr(OFS_TXCS, 32'h0000_002A);
        @(posedge tx_clk);
        carrier_cmd <= 1'b1;
        tick(5);
        chk(64'(tx_go_q), 64'h0);
        wr(OFS_TXCS, 32'h0000_0026);
        tick(2);
        chk(64'(tx_go_q), 64'h0);
        rd(OFS_TXCS, 32'h0000_1020);
        wr(OFS_TXCS, 32'h0000_0400);
        @(posedge tx_clk);
        collision <= 1'b1;
        @(posedge tx_clk);
        collision <= 1'b0;
        #1 chk(64'(backoff_q), 64'hF);
        rd(OFS_SEED, 32'h0000_00DF);
        results();
    end
endmodule
